/* File: logic/rtc_alarm_regs.svh */
// Purpose: register offsets, field positions, reset values and counts of the alarm and power gate
// Assumes: byte addresses on a 32-bit AXI4-Lite slave, one register per aligned word
// Notes: definitions only
`ifndef RTC_ALARM_REGS_SVH
`define RTC_ALARM_REGS_SVH

`define RTC_ADDR_W 8
`define RTC_OFF_CTL_LOW 8'h00
`define RTC_OFF_ALM_HIGH 8'h04
`define RTC_OFF_STAT_LOW 8'h08
`define RTC_OFF_SEC_UNITS 8'h0C
`define RTC_OFF_STABLE_LEN 8'h10
`define RTC_OFF_SAMPLE_LEN 8'h14
`define RTC_OFF_IRQ_STAT 8'h18
`define RTC_OFF_IRQ_MASK 8'h1C

// calendar_control_low fields
`define RTC_CAL_EN_BIT 15
`define RTC_PWC_EN_BIT 10
`define RTC_PWC_POL_BIT 9
`define RTC_PIN_OE_BIT 7
`define RTC_PIN_OUTPUT_SELECT_MSB 2
`define RTC_PIN_OUTPUT_SELECT_PWC 3'h3

// alarm_control_high fields
`define RTC_ALM_EN_BIT 15
`define RTC_CHIME_BIT 14
`define RTC_ALARM_INTERVAL_SELECT_MSB 11
`define RTC_ALARM_INTERVAL_SELECT_LSB 8
`define RTC_RPT_MSB 7
`define RTC_ALM_HIGH_MASK 16'hCFFF
`define RTC_ALARM_INTERVAL_SELECT_YEAR 4'h9
`define RTC_RPT_ALL_ONES 8'hFF

// calendar_status_low fields
`define RTC_ALM_FLAG_BIT 5
`define RTC_HALF_SEC_BIT 0

// interrupt status and mask bits
`define RTC_IRQ_W 2
`define RTC_IRQ_ALARM 0
`define RTC_IRQ_PWC_DONE 1

`define RTC_CNT_W 16
`define RTC_STABLE_DEF 16'h0010
`define RTC_SAMPLE_DEF 16'h0008
`define RTC_RESP_OKAY 2'h0
`define RTC_RESP_SLVERR 2'h2

`endif

/* File: logic/rtc_alarm_pkg.sv */
// Purpose: types shared by the alarm and power gate
// Assumes: constants come from rtc_alarm_regs.svh
// Notes: the whole block state is one packed struct
`include "rtc_alarm_regs.svh"
package rtc_alarm_pkg;

  typedef enum logic [2:0] {
    PWC_IDLE = 3'h1,
    PWC_STABLE = 3'h2,
    PWC_SAMPLE = 3'h4
  } pwc_e;

  typedef struct packed {
    pwc_e power_ctl_signal;
    logic [15:0] ctlLow;
    logic [15:0] almHigh;
    logic almFlag;
    logic half_second_phase;
    logic [3:0] secUnits;
    logic [`RTC_CNT_W-1:0] stableLen;
    logic [`RTC_CNT_W-1:0] sampleLen;
    logic [`RTC_CNT_W-1:0] winCnt;
    logic [`RTC_IRQ_W-1:0] irqStat;
    logic [`RTC_IRQ_W-1:0] irqMask;
    logic irq;
    logic pinOut;
    logic pinOe;
    logic sampleGate;
    logic pwrCtl;
    logic awHave;
    logic wHave;
    logic [`RTC_ADDR_W-1:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_s;

endpackage

/* File: logic/rtc_alarm_power_gate.sv */
// Purpose: alarm interval, repeat counter, alarm flag, half-second phase and power-control sequencer
// Assumes: sys_clk is also the timekeeping clock; calendar compare pulses arrive from outside
// Notes: registers on AXI4-Lite; one level interrupt
`timescale 1ns/1ps
`default_nettype none
`include "rtc_alarm_regs.svh"

module rtc_alarm_power_gate
  import rtc_alarm_pkg::*;
#(
  parameter int CNT_W = `RTC_CNT_W,
  parameter logic [`RTC_CNT_W-1:0] STABLE_DEF = `RTC_STABLE_DEF,
  parameter logic [`RTC_CNT_W-1:0] SAMPLE_DEF = `RTC_SAMPLE_DEF
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // calendar side
  input wire logic halfSecTick,
  input wire logic [9:0] almMatch,
  input wire logic alarmDateFeb29,
  input wire logic leapYear,
  // AXI4-Lite slave
  input wire logic [`RTC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`RTC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pin, gate and interrupt
  output logic calPinOut,
  output logic calPinOe,
  output logic sampleGate,
  output logic powerCtlActive,
  output logic irq
);

  generate
    if (CNT_W != `RTC_CNT_W) begin : g_bad_width
      $error("CNT_W must equal the packed state counter width");
    end
  endgenerate

  state_s st_r;
  state_s st_nxt;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) res[7:0] = d[7:0];
    if (strb[1]) res[15:8] = d[15:8];
    return res;
  endfunction

  logic calEn;
  logic almEn;
  logic chime;
  logic [3:0] alarm_interval_select;
  logic [7:0] rpt;
  logic intervalHit;
  logic almEvent;
  logic wrFire;
  logic pwcDone;
  logic [`RTC_IRQ_W-1:0] irqSet;
  logic [`RTC_IRQ_W-1:0] irqClr;
  logic ctlLevel;
  logic pinSel;

  always_comb begin
    calEn = st_r.ctlLow[`RTC_CAL_EN_BIT];
    almEn = st_r.almHigh[`RTC_ALM_EN_BIT];
    chime = st_r.almHigh[`RTC_CHIME_BIT];
    alarm_interval_select = st_r.almHigh[`RTC_ALARM_INTERVAL_SELECT_MSB:`RTC_ALARM_INTERVAL_SELECT_LSB];
    rpt = st_r.almHigh[`RTC_RPT_MSB:0];
    intervalHit = 1'b0;
    // reserved codes above 1001 never fire
    if (alarm_interval_select < `RTC_ALARM_INTERVAL_SELECT_YEAR) begin
      intervalHit = almMatch[alarm_interval_select];
    end else if (alarm_interval_select == `RTC_ALARM_INTERVAL_SELECT_YEAR) begin
      intervalHit = almMatch[alarm_interval_select] && (!alarmDateFeb29 || leapYear);
    end
    almEvent = calEn && almEn && intervalHit;
    wrFire = st_r.awHave && st_r.wHave && !st_r.bvalid;
    pwcDone = (st_r.power_ctl_signal == PWC_SAMPLE) && (st_r.winCnt <= `RTC_CNT_W'(1));
    irqSet = '0;
    irqSet[`RTC_IRQ_ALARM] = almEvent;
    irqSet[`RTC_IRQ_PWC_DONE] = pwcDone;
    irqClr = '0;
    if (wrFire && `RTC_ADDR_W'(st_r.awAddr[`RTC_ADDR_W-1:2]) == `RTC_OFF_IRQ_STAT >> 2
      && st_r.wStrb[0]) begin
      irqClr = st_r.wData[`RTC_IRQ_W-1:0];
    end

    st_nxt = st_r;

    // AXI write channel: address and data taken in either order
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.awHave = 1'b1;
      st_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.wHave = 1'b1;
      st_nxt.wData = s_axi_wdata;
      st_nxt.wStrb = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
      st_nxt.awHave = 1'b0;
      st_nxt.wHave = 1'b0;
    end
    if (wrFire) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = `RTC_RESP_OKAY;
      case (`RTC_ADDR_W'(st_r.awAddr[`RTC_ADDR_W-1:2]))
        `RTC_OFF_CTL_LOW >> 2: st_nxt.ctlLow = merge16(st_r.ctlLow, st_r.wData, st_r.wStrb);
        `RTC_OFF_ALM_HIGH >> 2: begin
          st_nxt.almHigh = merge16(st_r.almHigh, st_r.wData, st_r.wStrb) & `RTC_ALM_HIGH_MASK;
        end
        `RTC_OFF_STAT_LOW >> 2: begin
          // hardware set wins over the software clear
          if (st_r.wStrb[0] && st_r.wData[`RTC_ALM_FLAG_BIT] && !almEvent) begin
            st_nxt.almFlag = 1'b0;
          end
        end
        `RTC_OFF_SEC_UNITS >> 2: begin
          if (st_r.wStrb[0]) begin
            st_nxt.secUnits = st_r.wData[3:0];
          end
        end
        `RTC_OFF_STABLE_LEN >> 2: st_nxt.stableLen = merge16(st_r.stableLen, st_r.wData, st_r.wStrb);
        `RTC_OFF_SAMPLE_LEN >> 2: st_nxt.sampleLen = merge16(st_r.sampleLen, st_r.wData, st_r.wStrb);
        `RTC_OFF_IRQ_STAT >> 2: ;
        `RTC_OFF_IRQ_MASK >> 2: begin
          if (st_r.wStrb[0]) begin
            st_nxt.irqMask = st_r.wData[`RTC_IRQ_W-1:0];
          end
        end
        default: st_nxt.bresp = `RTC_RESP_SLVERR;
      endcase
    end
    st_nxt.awready = !st_nxt.awHave && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.wHave && !st_nxt.bvalid;

    // AXI read channel
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = `RTC_RESP_OKAY;
      st_nxt.rdata = '0;
      case (`RTC_ADDR_W'(s_axi_araddr[`RTC_ADDR_W-1:2]))
        `RTC_OFF_CTL_LOW >> 2: st_nxt.rdata[15:0] = st_r.ctlLow;
        `RTC_OFF_ALM_HIGH >> 2: st_nxt.rdata[15:0] = st_r.almHigh;
        `RTC_OFF_STAT_LOW >> 2: begin
          st_nxt.rdata[`RTC_ALM_FLAG_BIT] = st_r.almFlag;
          st_nxt.rdata[`RTC_HALF_SEC_BIT] = st_r.half_second_phase;
        end
        `RTC_OFF_SEC_UNITS >> 2: st_nxt.rdata[3:0] = st_r.secUnits;
        `RTC_OFF_STABLE_LEN >> 2: st_nxt.rdata[15:0] = st_r.stableLen;
        `RTC_OFF_SAMPLE_LEN >> 2: st_nxt.rdata[15:0] = st_r.sampleLen;
        `RTC_OFF_IRQ_STAT >> 2: st_nxt.rdata[`RTC_IRQ_W-1:0] = st_r.irqStat;
        `RTC_OFF_IRQ_MASK >> 2: st_nxt.rdata[`RTC_IRQ_W-1:0] = st_r.irqMask;
        default: st_nxt.rresp = `RTC_RESP_SLVERR;
      endcase
    end
    st_nxt.arready = !st_nxt.rvalid;

    // half-second phase: the seconds-units write beats the tick
    if (halfSecTick) begin
      st_nxt.half_second_phase = !st_r.half_second_phase;
    end
    if (wrFire && `RTC_ADDR_W'(st_r.awAddr[`RTC_ADDR_W-1:2]) == `RTC_OFF_SEC_UNITS >> 2
      && st_r.wStrb[0]) begin
      st_nxt.half_second_phase = 1'b0;
    end

    // alarm event; this overrides a same-cycle software write of the counter, except at a zero count with chime clear
    if (almEvent) begin
      st_nxt.almFlag = 1'b1;
      if (rpt != 8'h00) begin
        st_nxt.almHigh[`RTC_RPT_MSB:0] = rpt - 8'h01;
      end else if (chime) begin
        st_nxt.almHigh[`RTC_RPT_MSB:0] = `RTC_RPT_ALL_ONES;
      end else begin
        st_nxt.almHigh[`RTC_ALM_EN_BIT] = 1'b0;
      end
    end

    st_nxt.irqStat = (st_r.irqStat & ~irqClr) | irqSet;
    st_nxt.irq = |(st_nxt.irqStat & st_nxt.irqMask);

    // power-control sequencer, started by the alarm, no software in the loop
    case (st_r.power_ctl_signal)
      PWC_IDLE: begin
        if (almEvent && st_r.ctlLow[`RTC_PWC_EN_BIT]) begin
          st_nxt.power_ctl_signal = PWC_STABLE;
          st_nxt.winCnt = st_r.stableLen;
        end
      end
      PWC_STABLE: begin
        // a length of zero acts as one, so the count never wraps into a long wait
        st_nxt.winCnt = st_r.winCnt - `RTC_CNT_W'(1);
        if (st_r.winCnt <= `RTC_CNT_W'(1)) begin
          st_nxt.power_ctl_signal = PWC_SAMPLE;
          st_nxt.winCnt = st_r.sampleLen;
        end
      end
      PWC_SAMPLE: begin
        st_nxt.winCnt = st_r.winCnt - `RTC_CNT_W'(1);
        if (pwcDone) begin
          st_nxt.power_ctl_signal = PWC_IDLE;
          st_nxt.winCnt = '0;
        end
      end
      default: begin
        st_nxt.power_ctl_signal = PWC_IDLE;
        st_nxt.winCnt = '0;
      end
    endcase
    // a disable or calendar stop aborts the cycle and powers the device down
    if (!st_r.ctlLow[`RTC_PWC_EN_BIT] || !calEn) begin
      st_nxt.power_ctl_signal = PWC_IDLE;
      st_nxt.winCnt = '0;
    end

    ctlLevel = (st_nxt.power_ctl_signal != PWC_IDLE);
    st_nxt.pwrCtl = ctlLevel;
    st_nxt.sampleGate = (st_nxt.power_ctl_signal == PWC_SAMPLE);
    pinSel = st_nxt.ctlLow[`RTC_PIN_OE_BIT]
      && st_nxt.ctlLow[`RTC_PIN_OUTPUT_SELECT_MSB:0] == `RTC_PIN_OUTPUT_SELECT_PWC;
    st_nxt.pinOe = pinSel;
    st_nxt.pinOut = ctlLevel ^ !st_nxt.ctlLow[`RTC_PWC_POL_BIT];
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_r <= '0;
      st_r.power_ctl_signal <= PWC_IDLE;
      st_r.stableLen <= STABLE_DEF;
      st_r.sampleLen <= SAMPLE_DEF;
      st_r.pinOut <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = st_r.rdata;
  assign calPinOut = st_r.pinOut;
  assign calPinOe = st_r.pinOe;
  assign sampleGate = st_r.sampleGate;
  assign powerCtlActive = st_r.pwrCtl;
  assign irq = st_r.irq;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  alarm_self_clear_a: assert property (almEvent && rpt == 8'h00 && !chime |=>
    !st_r.almHigh[`RTC_ALM_EN_BIT]) else $error("alarm enable not cleared at zero count");
  repeat_wrap_a: assert property (almEvent && rpt == 8'h00 && chime |=>
    st_r.almHigh[`RTC_RPT_MSB:0] == 8'hFF && st_r.almHigh[`RTC_ALM_EN_BIT])
    else $error("repeat counter did not wrap");
  repeat_dec_a: assert property (almEvent && rpt != 8'h00 |=>
    st_r.almHigh[`RTC_RPT_MSB:0] == $past(rpt) - 8'h01) else $error("repeat counter not decremented");
  alarm_flag_a: assert property (almEvent |=> st_r.almFlag && st_r.irqStat[`RTC_IRQ_ALARM])
    else $error("alarm event flag not set");
  half_sec_clear_a: assert property (wrFire && st_r.wStrb[0] &&
    `RTC_ADDR_W'(st_r.awAddr[`RTC_ADDR_W-1:2]) == `RTC_OFF_SEC_UNITS >> 2 |=> !st_r.half_second_phase)
    else $error("half-second bit not forced to zero");
  pin_polarity_a: assert property (calPinOut ==
    (powerCtlActive ^ !st_r.ctlLow[`RTC_PWC_POL_BIT]))
    else $error("pin level does not follow control and polarity");
  stable_window_a: assert property ($rose(powerCtlActive) && st_r.stableLen == 16'h0003
    && st_r.ctlLow[`RTC_PWC_EN_BIT] && calEn |-> !sampleGate [*3])
    else $error("sample gate opened inside the stability window");
  window_close_a: assert property ($fell(sampleGate) |-> !powerCtlActive)
    else $error("control output outlived the sample window");
  gate_inside_a: assert property (sampleGate |-> powerCtlActive)
    else $error("sample gate open without control output");
  // the checks below look at registered state and the calendar inputs, never at the next-state copy
  repeat_stop_a: assert property (almEvent && rpt == 8'h00 && !chime |=>
    st_r.almHigh[`RTC_RPT_MSB:0] == 8'h00)
    else $error("repeat counter moved past zero");
  reserved_code_a: assert property (!st_r.almFlag && alarm_interval_select > `RTC_ALARM_INTERVAL_SELECT_YEAR |=>
    !st_r.almFlag)
    else $error("reserved interval code raised an alarm");
  leap_gate_a: assert property (!st_r.almFlag && alarm_interval_select == `RTC_ALARM_INTERVAL_SELECT_YEAR
    && alarmDateFeb29 && !leapYear |=> !st_r.almFlag)
    else $error("leap-day alarm fired outside a leap year");
  count_hold_a: assert property (!almEn && !wrFire |=>
    $stable(st_r.almHigh[`RTC_RPT_MSB:0]))
    else $error("repeat counter moved while alarm disabled");
  sample_window_a: assert property ($rose(sampleGate) && st_r.winCnt == 16'h0002
    |-> sampleGate [*2] ##1 !sampleGate)
    else $error("sample window length wrong");
  done_flag_a: assert property ($fell(powerCtlActive) && st_r.ctlLow[`RTC_PWC_EN_BIT]
    && calEn |-> st_r.irqStat[`RTC_IRQ_PWC_DONE])
    else $error("end of power cycle not flagged");
  pin_enable_a: assert property (calPinOe == (st_r.ctlLow[`RTC_PIN_OE_BIT]
    && st_r.ctlLow[`RTC_PIN_OUTPUT_SELECT_MSB:0] == `RTC_PIN_OUTPUT_SELECT_PWC))
    else $error("pin output enable does not follow the select");
  status_ro_a: assert property (wrFire && !halfSecTick
    && `RTC_ADDR_W'(st_r.awAddr[`RTC_ADDR_W-1:2]) == `RTC_OFF_STAT_LOW >> 2
    |=> st_r.half_second_phase == $past(st_r.half_second_phase)) else $error("half-second bit was written");

endmodule
`default_nettype wire

/* File: tb/ext_peripheral.sv */
// Purpose: external switched peripheral powered through the calendar pin
// Assumes: the bench resolves the pin wire, pull-up when undriven
// Notes: reports the length of the last powered period in clock cycles
`timescale 1ns/1ps
`default_nettype none

module ext_peripheral (
  // clock
  input wire logic sys_clk,
  // supply control
  input wire logic pinLevel,
  input wire logic activeHigh,
  // observation
  output logic powered,
  output logic [15:0] onCycles
);
  logic [15:0] runCnt = 16'h0000;
  logic [15:0] lastLen = 16'h0000;

  // active-low with pull-up drives the ground side directly
  assign powered = (pinLevel === activeHigh);
  assign onCycles = lastLen;

  always @(posedge sys_clk) begin
    if (powered) begin
      runCnt <= runCnt + 16'h0001;
    end else if (runCnt != 16'h0000) begin
      lastLen <= runCnt;
      runCnt <= 16'h0000;
    end
  end
endmodule

`default_nettype wire

/* File: tb/tb_top.sv */
// Purpose: self-checking bench of the alarm and power gate
// Assumes: AXI4-Lite master tasks, far side modelled by ext_peripheral
// Notes: table loop over interval codes, then hand-written cases
`timescale 1ns/1ps
`default_nettype none
`include "rtc_alarm_regs.svh"

module tb_top;
  typedef struct packed {logic [3:0] code; logic [3:0] k; logic feb; logic leap; logic flag;} row_s;
  localparam logic [7:0] CTL = `RTC_OFF_CTL_LOW;
  localparam logic [7:0] ALM = `RTC_OFF_ALM_HIGH;
  localparam logic [7:0] STAT = `RTC_OFF_STAT_LOW;
  localparam logic [7:0] IST = `RTC_OFF_IRQ_STAT;
  localparam logic [7:0] IMSK = `RTC_OFF_IRQ_MASK;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic halfSecTick = 1'b0;
  logic [9:0] almMatch = 10'h000;
  logic feb29 = 1'b0;
  logic leap = 1'b0;
  logic activeHigh = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic calPinOut, calPinOe, sampleGate, powerCtlActive, irq, powered, pinWire;
  logic [15:0] onCycles;
  int n_errors = 0;
  int comparisons = 0;
  int actCnt = 0;
  int gateCnt = 0;
  int a0, g0;
  row_s rows [14];

  always #10 sys_clk = ~sys_clk;
  assign pinWire = calPinOe ? calPinOut : 1'b1;

  always @(posedge sys_clk) begin
    if (powerCtlActive === 1'b1) actCnt <= actCnt + 1;
    if (sampleGate === 1'b1) gateCnt <= gateCnt + 1;
  end

  rtc_alarm_power_gate i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .halfSecTick(halfSecTick),
    .almMatch(almMatch), .alarmDateFeb29(feb29), .leapYear(leap), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .calPinOut(calPinOut), .calPinOe(calPinOe), .sampleGate(sampleGate),
    .powerCtlActive(powerCtlActive), .irq(irq));

  ext_peripheral i_ext (.sys_clk(sys_clk), .pinLevel(pinWire), .activeHigh(activeHigh),
    .powered(powered), .onCycles(onCycles));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge sys_clk);
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge sys_clk);
    d = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rdr(a, rd);
    chk(rd, exp);
  endtask

  task automatic pulse(input int k);
    @(posedge sys_clk);
    almMatch <= 10'h001 << k;
    @(posedge sys_clk);
    almMatch <= 10'h000;
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    close_out();
  end

  initial begin
    for (int i = 0; i < 10; i++) rows[i] = '{4'(i), 4'(i), 1'b0, 1'b0, 1'b1};
    rows[10] = '{4'h9, 4'h9, 1'b1, 1'b0, 1'b0};
    rows[11] = '{4'h9, 4'h9, 1'b1, 1'b1, 1'b1};
    rows[12] = '{4'h5, 4'h6, 1'b0, 1'b0, 1'b0};
    rows[13] = '{4'hA, 4'h9, 1'b0, 1'b0, 1'b0};
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    chk(calPinOut, 32'h1);
    chk({calPinOe, sampleGate, powerCtlActive, irq}, 32'h0);
    rchk(ALM, 32'h0);
    rchk(STAT, 32'h0);
    rchk(`RTC_OFF_STABLE_LEN, 32'h10);
    rchk(`RTC_OFF_SAMPLE_LEN, 32'h8);
    $display("test reset done");
    wr(CTL, 32'h8000);
    for (int i = 0; i < 14; i++) begin
      feb29 <= rows[i].feb;
      leap <= rows[i].leap;
      wr(ALM, {16'h0000, 4'h8, rows[i].code, 8'h05});
      pulse(rows[i].k);
      rchk(STAT, {26'h0, rows[i].flag, 5'h00});
      rchk(ALM, {16'h0000, 4'h8, rows[i].code, rows[i].flag ? 8'h04 : 8'h05});
      wr(STAT, 32'h20);
    end
    rchk(STAT, 32'h0);
    $display("test interval table done");
    wr(ALM, 32'h8001);
    pulse(0);
    rchk(ALM, 32'h8000);
    pulse(0);
    rchk(ALM, 32'h0000);
    wr(STAT, 32'h20);
    pulse(0);
    rchk(STAT, 32'h0);
    wr(ALM, 32'hC000);
    pulse(0);
    rchk(ALM, 32'hC0FF);
    wr(STAT, 32'h20);
    @(posedge sys_clk) halfSecTick <= 1'b1;
    @(posedge sys_clk) halfSecTick <= 1'b0;
    rchk(STAT, 32'h1);
    wr(STAT, 32'h1);
    rchk(STAT, 32'h1);
    wr(`RTC_OFF_SEC_UNITS, 32'h5);
    rchk(STAT, 32'h0);
    wr(8'h20, 32'hFFFF);
    chk(rsp, `RTC_RESP_SLVERR);
    rdr(8'h20, rd);
    chk(rd, 32'h0);
    chk(rsp, `RTC_RESP_SLVERR);
    $display("test repeat and status done");
    wr(`RTC_OFF_STABLE_LEN, 32'h3);
    wr(`RTC_OFF_SAMPLE_LEN, 32'h2);
    wr(IMSK, 32'h2);
    wr(IST, 32'h3);
    wr(CTL, 32'h8483);
    chk({calPinOe, pinWire}, 32'h3);
    a0 = actCnt;
    g0 = gateCnt;
    pulse(0);
    for (int t = 0; t < 60 && irq !== 1'b1; t++) @(posedge sys_clk);
    chk(irq, 32'h1);
    chk(actCnt - a0, 32'h5);
    chk(gateCnt - g0, 32'h2);
    @(posedge sys_clk);
    chk({onCycles, 15'h0, powerCtlActive}, {16'h5, 16'h0});
    rchk(IST, 32'h3);
    wr(IST, 32'h3);
    chk(irq, 32'h0);
    wr(IMSK, 32'h0);
    activeHigh <= 1'b1;
    wr(CTL, 32'h8683);
    chk(pinWire, 32'h0);
    wr(`RTC_OFF_STABLE_LEN, 32'h4);
    pulse(0);
    repeat (20) @(posedge sys_clk);
    chk({onCycles, irq}, {16'h6, 1'b0});
    rchk(IST, 32'h3);
    wr(CTL, 32'h8682);
    chk({calPinOe, pinWire}, 32'h1);
    $display("test power control done");
    @(posedge sys_clk) rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    chk({calPinOut, calPinOe, powerCtlActive, irq}, 32'h8);
    rchk(CTL, 32'h0);
    rchk(`RTC_OFF_STABLE_LEN, 32'h10);
    $display("test mid-run reset done");
    close_out();
  end
endmodule

`default_nettype wire
